// >>> verilog/mcs_sequencer.v
// mcs_sequencer.v: conversion sequencer and parallel host interface
`timescale 1ns/10ps
`default_nettype none
`include "mcs_defines.vh"
module mcs_sequencer #(
  parameter NUM_CH = 8
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_conversion_start,
  input wire i_power_down_in,
  input wire i_idle_input_powerdown_n,
  input wire i_clock_source_select,
  input wire i_ext_clk,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire [7:0] i_data_in,
  input wire [`MCS_RES_W-1:0] i_conv_result,
  output reg [`MCS_RES_W-1:0] o_data_out,
  output reg o_data_oe,
  output reg o_sample_hold,
  output reg [`MCS_CH_W-1:0] o_conv_channel,
  output reg [`MCS_CFG_W-1:0] o_channel_power,
  output reg o_result_ready_n,
  output reg o_final_result_flag_n
);
  // ------------------------------------------------------------
  // states and constants
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;
  localparam [1:0] ST_POWER_DOWN_IN = 2'h3;
  localparam [`MCS_CFG_W-1:0] CH_MASK = ~({`MCS_CFG_W{1'b1}} << NUM_CH);
  localparam BW = `MCS_RES_W + 1;

  // lowest set bit of a channel set
  function [`MCS_CH_W-1:0] low_ch;
    input [`MCS_CFG_W-1:0] set;
    integer i;
    begin
      low_ch = 3'h0;
      for (i = `MCS_CFG_W - 1; i >= 0; i = i - 1) begin
        if (set[i]) begin
          low_ch = i[`MCS_CH_W-1:0];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // input edge history and strap capture
  // ------------------------------------------------------------
  reg conv_q;
  reg pd_q;
  reg wr_n_q;
  reg cs_n_q;
  reg rd_act_q;
  reg [7:0] din_q;
  reg use_int_q;
  wire rd_act = ~i_cs_n & ~i_rd_n;
  wire start_fall = conv_q & ~i_conversion_start;
  wire start_rise = ~conv_q & i_conversion_start;
  wire pd_fall = pd_q & ~i_power_down_in;
  wire rd_begin = rd_act & ~rd_act_q;

  // pin history; strap is taken every cycle after reset release
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_q <= 1'b0;
      pd_q <= 1'b0;
      wr_n_q <= 1'b1;
      cs_n_q <= 1'b1;
      rd_act_q <= 1'b0;
      din_q <= 8'h00;
      use_int_q <= 1'b1;
    end else begin
      conv_q <= i_conversion_start;
      pd_q <= i_power_down_in;
      wr_n_q <= i_wr_n;
      cs_n_q <= i_cs_n;
      rd_act_q <= rd_act;
      din_q <= i_data_in;
      use_int_q <= i_clock_source_select;
    end
  end

  // ------------------------------------------------------------
  // configuration byte
  // ------------------------------------------------------------
  reg [`MCS_CFG_W-1:0] cfg_q;
  reg [`MCS_CFG_W-1:0] active_q;
  wire wr_rise = ~wr_n_q & i_wr_n & ~cs_n_q;

  // byte held across the low write strobe, taken at its rise
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= `MCS_CFG_RESET;
    end else if (wr_rise) begin
      cfg_q <= din_q;
    end
  end

  // channel set in use, updated only at a start fall
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      active_q <= `MCS_CFG_RESET & CH_MASK;
    end else if (start_fall) begin
      active_q <= cfg_q & CH_MASK;
    end
  end

  // ------------------------------------------------------------
  // conversion clock
  // ------------------------------------------------------------
  wire tick;
  mcs_tick_gen u_tick (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_use_internal(use_int_q),
    .i_ext_clk(i_ext_clk),
    .o_tick(tick)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  reg [1:0] st_q;
  reg [`MCS_CFG_W-1:0] rem_q;
  reg [3:0] ph_q;
  reg due_q;
  wire buf_in_ready;
  wire abort = start_fall | i_power_down_in;
  wire launch = (start_rise & ~i_power_down_in) | pd_fall;
  wire push = (st_q == ST_CONV) & due_q & buf_in_ready & ~abort;
  wire last_one = (rem_q & (rem_q - 8'h01)) == 8'h00;
  // internal rate runs free from reset and does not restart with the start; the start edge still counts as a tick
  wire [3:0] first_ph = use_int_q ? `MCS_FIRST_TICKS_INT : `MCS_FIRST_TICKS;

  // start, tick countdown, channel walk, abort
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= ST_IDLE;
      rem_q <= 8'h00;
      ph_q <= 4'h0;
      due_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE, ST_DONE: begin
          due_q <= 1'b0;
          if (i_power_down_in) begin
            st_q <= ST_POWER_DOWN_IN;
          end else if (start_fall) begin
            st_q <= ST_IDLE;
          end else if (launch && active_q != 8'h00) begin
            st_q <= ST_CONV;
            rem_q <= active_q;
            ph_q <= first_ph;
          end
        end
        ST_CONV: begin
          if (i_power_down_in) begin
            st_q <= ST_POWER_DOWN_IN;
            due_q <= 1'b0;
          end else if (start_fall) begin
            st_q <= ST_IDLE;
            due_q <= 1'b0;
          end else begin
            if (tick && ph_q == 4'h1) begin
              ph_q <= `MCS_NEXT_TICKS;
              due_q <= 1'b1;
            end else if (tick) begin
              ph_q <= ph_q - 4'h1;
            end
            if (push) begin
              rem_q <= rem_q & ~(8'h01 << low_ch(rem_q));
              if (!(tick && ph_q == 4'h1)) begin
                due_q <= 1'b0;
              end
              if (last_one) begin
                st_q <= ST_DONE;
              end
            end
          end
        end
        ST_POWER_DOWN_IN: begin
          due_q <= 1'b0;
          if (!i_power_down_in) begin
            if (active_q != 8'h00) begin
              st_q <= ST_CONV;
              rem_q <= active_q;
              ph_q <= first_ph;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // result buffer and result store
  // ------------------------------------------------------------
  wire buf_out_valid;
  wire [BW-1:0] buf_out;
  wire store_ready = ~rd_act; // store stalls while a read is open
  wire store_wr = buf_out_valid & store_ready;

  mcs_buf2 #(.W(BW)) u_buf (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_flush(abort),
    .i_valid(push),
    .o_ready(buf_in_ready),
    .i_data({last_one, i_conv_result}),
    .o_valid(buf_out_valid),
    .i_ready(store_ready),
    .o_data(buf_out)
  );

  reg [`MCS_RES_W-1:0] res_mem [0:`MCS_CFG_W-1];
  reg [`MCS_CH_W:0] wcnt_q;
  reg [`MCS_CH_W-1:0] rptr_q;

  // results land in order; abort empties the store
  always @(posedge i_core_clk) begin
    if (store_wr && !abort) begin
      res_mem[wcnt_q[`MCS_CH_W-1:0]] <= buf_out[`MCS_RES_W-1:0];
    end
  end

  // write count and read pointer with wrap to the first result
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wcnt_q <= 4'h0;
      rptr_q <= 3'h0;
    end else if (abort) begin
      wcnt_q <= 4'h0;
      rptr_q <= 3'h0;
    end else begin
      if (store_wr) begin
        wcnt_q <= wcnt_q + 4'h1;
      end
      if (rd_begin) begin
        if ({1'b0, rptr_q} + 4'h1 >= wcnt_q) begin
          rptr_q <= 3'h0;
        end else begin
          rptr_q <= rptr_q + 3'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // host-facing outputs
  // ------------------------------------------------------------
  // bus driven only while select and read are both low
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data_out <= 12'h000;
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= rd_act;
      if (rd_begin) begin
        o_data_out <= res_mem[rptr_q];
      end
    end
  end

  // flags, hold control, converter channel and input power
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_result_ready_n <= 1'b1;
      o_final_result_flag_n <= 1'b1;
      o_sample_hold <= 1'b0;
      o_conv_channel <= 3'h0;
      o_channel_power <= 8'h00;
    end else begin
      o_result_ready_n <= ~(store_wr & ~abort);
      if (abort) begin
        o_final_result_flag_n <= 1'b1;
      end else if (store_wr && buf_out[BW-1]) begin
        o_final_result_flag_n <= 1'b0;
      end
      o_sample_hold <= i_conversion_start & ~i_power_down_in;
      o_conv_channel <= low_ch(rem_q);
      o_channel_power <= i_power_down_in ? 8'h00 :
        ((i_idle_input_powerdown_n ? 8'hFF : active_q) & CH_MASK);
    end
  end
endmodule // mcs_sequencer
`default_nettype wire

// >>> verilog/mcs_defines.vh
// mcs_defines.vh: constants of the conversion sequencer
`ifndef MCS_DEFINES_VH
`define MCS_DEFINES_VH
// channel-enable configuration
`define MCS_CFG_W 8
`define MCS_CFG_RESET 8'hFF
// result word and channel index widths
`define MCS_RES_W 12
`define MCS_CH_W 3
`define MCS_CH_MAX 3'h7
// conversion-clock ticks to the first result, and between results
`define MCS_FIRST_TICKS 4'hD
`define MCS_NEXT_TICKS 4'h3
// internal mode counts the start as its first clock edge
`define MCS_FIRST_TICKS_INT 4'hC
// internal oscillator made from the core clock as a rational rate
`define MCS_CORE_MHZ 6'h14
`define MCS_INT_OSC_MHZ 6'h0F
`define MCS_OSC_ACC_W 6
`endif

// >>> verilog/mcs_tick_gen.v
// mcs_tick_gen.v: conversion-clock tick from internal rate or external clock
`timescale 1ns/10ps
`default_nettype none
`include "mcs_defines.vh"
module mcs_tick_gen (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_use_internal,
  input wire i_ext_clk,
  output reg o_tick
);
  localparam [`MCS_OSC_ACC_W-1:0] STEP = `MCS_INT_OSC_MHZ;
  localparam [`MCS_OSC_ACC_W-1:0] WRAP = `MCS_CORE_MHZ;
  reg [`MCS_OSC_ACC_W-1:0] acc_q;
  reg [`MCS_OSC_ACC_W-1:0] acc_d;
  reg ext_q;
  reg int_tick;
  // fractional accumulator: STEP ticks every WRAP core cycles
  always @* begin
    acc_d = acc_q + STEP;
    int_tick = 1'b0;
    if (acc_d >= WRAP) begin
      acc_d = acc_d - WRAP;
      int_tick = 1'b1;
    end
  end
  // external mode ticks on each rising edge of the sampled clock pin
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_q <= 6'h00;
      ext_q <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      acc_q <= acc_d;
      ext_q <= i_ext_clk;
      o_tick <= i_use_internal ? int_tick : (i_ext_clk & ~ext_q);
    end
  end
endmodule // mcs_tick_gen
`default_nettype wire

// >>> verilog/mcs_buf2.v
// mcs_buf2.v: two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module mcs_buf2 #(
  parameter W = 16
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_flush,
  input wire i_valid,
  output wire o_ready,
  input wire [W-1:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [W-1:0] o_data
);
  reg [W-1:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push = i_valid && (cnt_q != 2'h2);
  wire pop = i_ready && (cnt_q != 2'h0);
  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data = mem_q[rp_q];
  // storage and pointers; flush drops everything held
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (i_flush) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  // data array has no reset
  always @(posedge i_core_clk) begin
    if (push && !i_flush) begin
      mem_q[wp_q] <= i_data;
    end
  end
endmodule // mcs_buf2
`default_nettype wire

// >>> verification/mcs_seq_monitor.sv
// mcs_seq_monitor.sv: port checker of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
`include "mcs_defines.vh"
module mcs_seq_monitor (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_conversion_start,
  input wire logic i_power_down_in,
  input wire logic i_clock_source_select,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic [`MCS_RES_W-1:0] o_data_out,
  input wire logic o_data_oe,
  input wire logic o_sample_hold,
  input wire logic o_result_ready_n,
  input wire logic o_final_result_flag_n
);
  // ----------------------------------------
  // assertions on bus, strobes and flags
  // ----------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_float; (i_cs_n || i_rd_n) |=> !o_data_oe; endproperty
  a_float: assert property (p_float) else $error("bus not floated");
  property p_drive; (!i_cs_n && !i_rd_n) |=> o_data_oe; endproperty
  a_drive: assert property (p_drive) else $error("read not driven");
  property p_hold; o_data_oe && $past(o_data_oe) |-> $stable(o_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_pulse; !o_result_ready_n |=> o_result_ready_n; endproperty
  a_pulse: assert property (p_pulse) else $error("ready pulse long");
  property p_last; $fell(o_final_result_flag_n) |-> !o_result_ready_n;
  endproperty
  a_last: assert property (p_last) else $error("last flag alone");
  property p_clear;
    $fell(i_conversion_start) |-> ##[1:3] o_final_result_flag_n;
  endproperty
  a_clear: assert property (p_clear) else $error("last flag stuck");
  property p_power_down_in;
    i_power_down_in [*2] |-> o_result_ready_n && o_final_result_flag_n;
  endproperty
  a_power_down_in: assert property (p_power_down_in) else $error("flags low in shutdown");
  property p_first; $rose(o_sample_hold) && i_clock_source_select
    |-> ##[13:18] (!o_result_ready_n || !o_sample_hold); endproperty
  a_first: assert property (p_first) else $error("first result late");
  property p_track;
    (!i_conversion_start || i_power_down_in) |=> !o_sample_hold;
  endproperty
  a_track: assert property (p_track) else $error("hold while tracking");
  // main scenarios reached
  c_ext: cover property (!o_result_ready_n && !i_clock_source_select);
  c_last: cover property ($fell(o_final_result_flag_n));
  c_wake: cover property ($fell(i_power_down_in));
endmodule // mcs_seq_monitor
bind mcs_sequencer mcs_seq_monitor u_mon (.i_core_clk(i_core_clk),
  .i_resetn(i_resetn), .i_conversion_start(i_conversion_start),
  .i_power_down_in(i_power_down_in), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
  .i_clock_source_select(i_clock_source_select), .o_data_oe(o_data_oe),
  .o_data_out(o_data_out), .o_sample_hold(o_sample_hold),
  .o_result_ready_n(o_result_ready_n),
  .o_final_result_flag_n(o_final_result_flag_n));
`default_nettype wire

// >>> verification/mcs_conv_model.sv
// mcs_conv_model.sv: converter core model feeding result words
`timescale 1ns/10ps
`default_nettype none
module mcs_conv_model (
  input wire logic i_core_clk,
  input wire logic i_hold,
  input wire logic [2:0] i_channel,
  output logic [11:0] o_value
);
  logic h_q = 1'b0;
  logic [8:0] tag_q = 9'h000;
  // new sample set on each hold rise
  always @(posedge i_core_clk) begin
    h_q <= i_hold;
    if (i_hold && !h_q) tag_q <= tag_q + 9'h001;
  end
  // word names sample set and channel; inverted while tracking
  assign o_value = i_hold ? {tag_q, i_channel} : ~{tag_q, i_channel};
endmodule // mcs_conv_model
`default_nettype wire

// >>> verification/mcs_sequencer_tb.sv
// mcs_sequencer_tb.sv: self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module mcs_sequencer_tb;
  logic clk, rstn, start, pd, sel, ext, cs_n, rd_n, wr_n, oe, oe_p;
  logic sh, rdy_n, fin_n, en_ext, idle_n;
  logic [7:0] din, cur, nxt, pw;
  logic [2:0] ch;
  logic [11:0] res, dout;
  logic [11:0] exp_q[$];
  logic [11:0] edge_q[$];
  int fails, check_count, pulses, eedges, run, div;
  mcs_sequencer u_dut (.i_core_clk(clk), .i_resetn(rstn),
    .i_conversion_start(start), .i_power_down_in(pd),
    .i_idle_input_powerdown_n(idle_n), .i_clock_source_select(sel),
    .i_ext_clk(ext), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_data_in(din), .i_conv_result(res), .o_data_out(dout),
    .o_data_oe(oe), .o_sample_hold(sh), .o_conv_channel(ch),
    .o_channel_power(pw), .o_result_ready_n(rdy_n),
    .o_final_result_flag_n(fin_n));
  mcs_conv_model u_conv (.i_core_clk(clk), .i_hold(sh), .i_channel(ch),
    .o_value(res));
  // ----------------------------------------
  // clock, external clock, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // external clock of 8 core cycles, still outside frames
  always @(posedge clk) begin
    if (en_ext) begin
      div <= div + 1;
      if (div % 4 == 3) begin
        ext <= ~ext;
        if (!ext) eedges <= eedges + 1;
      end
    end
  end
  initial begin
    #(50 * 20000);
    fails++;
    $display("[ERR] %0t timeout", $time);
    results;
  end
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task chk(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // pulses against edge notes, read words against result notes
  always @(posedge clk) begin
    if (!rdy_n) begin
      pulses++;
      if (edge_q.size() > 0) chk(eedges[11:0], edge_q.pop_front());
    end
    if (oe && !oe_p) chk(dout, exp_q.size() ? exp_q.pop_front() : 'x);
    oe_p = oe;
  end
  task results;
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // bus tasks and one conversion frame
  // ----------------------------------------
  task wr(input logic [7:0] b);
    @(posedge clk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    din <= b;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    din <= ~b;
    @(posedge clk);
  endtask
  task rd;
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge clk);
  endtask
  task conv(input logic [7:0] cfg, input logic [7:0] nx, input bit w, x);
    int i, n;
    n = 0;
    for (i = 0; i < 8; i++) n += cfg[i];
    for (i = 0; i < n && x; i++) edge_q.push_back(12'(13 + 3 * i));
    pulses = 0;
    eedges = 0;
    sel <= !x;
    en_ext <= x;
    idle_n <= ~idle_n;
    @(posedge clk);
    if (w) pd <= 1'b0;
    else start <= 1'b1;
    run++;
    wr(nx);
    i = 0;
    while (fin_n !== 1'b0 && i < 600) begin
      @(posedge clk);
      i++;
    end
    @(posedge clk);
    chk(12'(pulses), 12'(n));
    chk({4'h0, pw}, {4'h0, idle_n ? 8'hFF : cfg});
    for (i = 0; i < 8; i++) if (cfg[i]) exp_q.push_back({run[8:0], i[2:0]});
    exp_q.push_back(exp_q[0]);
    repeat (n + 1) rd();
    en_ext <= 1'b0;
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    chk({11'h000, fin_n}, 12'h001);
    repeat (2) @(posedge clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn, start, pd, ext, en_ext, oe_p, idle_n} = 7'h00;
    {sel, cs_n, rd_n, wr_n} = 4'hF;
    din = 8'h00;
    {fails, check_count, pulses, eedges, run, div} = 192'h0;
    void'($urandom(32'h2473));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    cur = 8'hFF;
    repeat (3) begin
      nxt = 8'($urandom) | 8'h10;
      conv(cur, nxt, 1'b0, 1'b0);
      cur = nxt;
    end
    conv(cur, 8'h88, 1'b0, 1'b1);
    // abort in mid-conversion, then a clean frame
    pulses = 0;
    sel <= 1'b1;
    @(posedge clk);
    start <= 1'b1;
    run++;
    repeat (10) @(posedge clk);
    start <= 1'b0;
    repeat (30) @(posedge clk);
    chk(12'(pulses), 12'h000);
    conv(8'h88, 8'h5A, 1'b0, 1'b0);
    // shutdown: write accepted, its end starts a frame
    pd <= 1'b1;
    wr(8'h03);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    start <= 1'b1;
    repeat (4) @(posedge clk);
    chk({10'h000, rdy_n, fin_n}, 12'h003);
    chk({4'h0, pw}, 12'h000);
    conv(8'h03, 8'h03, 1'b1, 1'b0);
    results;
  end
endmodule // mcs_sequencer_tb
`default_nettype wire
